/* rtl/ubbp_device.sv */
`timescale 1ns/1ps
`include "ubbp_params.svh"
module ubbp_device
  import ubbp_pkg::*;
#(
  parameter logic [15:0] BAUD_DIV = `UBBP_BAUD_DIV
)
(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       setup_valid,
  input  wire logic [7:0] setup_mode,
  input  wire logic [7:0] setup_dir_mask,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  output logic            rx_ready,
  input  wire logic       tx_ready,
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  output logic [7:0]      mode,
  ubbp_if.device          port
);
  logic [7:0]     mode_reg;
  logic [7:0]     dir_reg;
  logic [7:0]     pins_reg;
  logic [15:0]    baud_cnt_reg;
  logic           baud_tick;
  logic           rd_n_reg;
  logic           wr_n_reg;
  logic           rx_ready_reg;
  logic           tx_valid_reg;
  logic [7:0]     tx_data_reg;
  logic [7:0]     hold_reg;
  ubbp_state_type state_reg;
  logic           is_async;
  logic           is_sync;
  logic           take_async;
  logic           take_sync;

  ////////////////////////////////////////////////////////////////////////////
  assign is_async = (mode_reg == `UBBP_MODE_ASYNC);
  assign is_sync  = (mode_reg == `UBBP_MODE_SYNC);
  assign baud_tick = (baud_cnt_reg == 16'h0000);
  // Async takes a byte only when one waits and the baud tick falls.
  assign take_async = is_async && rx_valid && baud_tick && state_reg == UBBP_IDLE; // RULE4
  // Sync refuses to start while the host side cannot take a sample.
  assign take_sync = is_sync && rx_valid && tx_ready && !tx_valid_reg && state_reg == UBBP_IDLE; // RULE9
  assign rx_ready = rx_ready_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_data  = tx_data_reg;
  assign mode     = mode_reg;
  assign port.pins_out = pins_reg;
  assign port.pins_oe  = dir_reg; // RULE18
  assign port.pin_sample_strobe_n = rd_n_reg;
  assign port.pin_update_strobe_n = wr_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_reg <= `UBBP_MODE_RESET;
      dir_reg  <= `UBBP_DIR_RESET;
    end
    else if (setup_valid && state_reg == UBBP_IDLE)
    begin
      if (setup_mode == `UBBP_MODE_ASYNC || setup_mode == `UBBP_MODE_SYNC || setup_mode == `UBBP_MODE_RESET)
      begin
        mode_reg <= setup_mode; // RULE11 RULE12
      end
      dir_reg <= setup_dir_mask; // RULE16 RULE3
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      baud_cnt_reg <= 16'h0000;
    end
    else if (baud_tick)
    begin
      baud_cnt_reg <= BAUD_DIV - 16'h0001;
    end
    else
    begin
      baud_cnt_reg <= baud_cnt_reg - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins only ever move here; masked-off bits still store but are not driven.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg    <= UBBP_IDLE;
      pins_reg     <= `UBBP_PINS_RESET;
      hold_reg     <= 8'h00;
      rd_n_reg     <= 1'b1; // RULE19
      wr_n_reg     <= 1'b1;
      rx_ready_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= 8'h00;
    end
    else
    begin
      rx_ready_reg <= 1'b0;
      if (tx_valid_reg && tx_ready)
      begin
        tx_valid_reg <= 1'b0;
      end
      case (state_reg)
        UBBP_IDLE:
        begin
          wr_n_reg <= 1'b1;
          rd_n_reg <= 1'b1;
          if (take_async)
          begin
            pins_reg     <= rx_data; // RULE2 RULE5
            rx_ready_reg <= 1'b1;
            wr_n_reg     <= 1'b0; // RULE1
            rd_n_reg     <= 1'b0;
            state_reg    <= UBBP_STROBE;
          end
          else if (take_sync)
          begin
            hold_reg     <= rx_data; // RULE6 RULE8
            rx_ready_reg <= 1'b1;
            rd_n_reg     <= 1'b0;
            state_reg    <= UBBP_SAMPLE;
          end
        end
        UBBP_SAMPLE:
        begin
          rd_n_reg     <= 1'b1; // RULE13
          tx_data_reg  <= port.pins_in; // RULE10
          tx_valid_reg <= 1'b1;
          state_reg    <= UBBP_APPLY;
        end
        UBBP_APPLY:
        begin
          rd_n_reg  <= 1'b0; // RULE13
          pins_reg  <= hold_reg;
          state_reg <= UBBP_SETUP;
        end
        UBBP_SETUP:
        begin
          wr_n_reg  <= 1'b0; // RULE14 RULE7
          state_reg <= UBBP_STROBE;
        end
        UBBP_STROBE:
        begin
          wr_n_reg  <= 1'b1; // RULE14
          rd_n_reg  <= 1'b1; // RULE19
          state_reg <= UBBP_IDLE;
        end
        default:
        begin
          state_reg <= UBBP_IDLE;
        end
      endcase
    end
  end
endmodule

/* shared/ubbp_params.svh */
// Summary of operation
// RULE1 - Async mode brings strobes out to pins.
// RULE2 - Async mode drives host bytes onto outputs.
// RULE3 - Each pin individually input or output.
// RULE4 - Async output pace set by baud ticks.
// RULE5 - Pins change on new byte plus tick.
// RULE6 - Sync mode updates pins only on host byte.
// RULE7 - Sync update strobe after byte placed on pins.
// RULE8 - Sync sampling only caused by host write.
// RULE9 - Sync waits for room toward host.
// RULE10 - Sync samples pins before applying byte.
// RULE11 - Mode command value 1 selects async.
// RULE12 - Mode command value 4 selects sync.
// RULE13 - Sample strobe high while capturing, low on update.
// RULE14 - One setup cycle, then update strobe pulse.
// RULE15 - Sample strobe rising edge marks capture.
// RULE16 - Setup command carries direction mask, held.
// RULE17 - All-input still needs writes to sample.
// RULE18 - Mask one is output, zero input.
// RULE19 - Strobes active low, idle high.
`ifndef UBBP_PARAMS_SVH
`define UBBP_PARAMS_SVH
`define UBBP_MODE_RESET    8'h00
`define UBBP_MODE_ASYNC    8'h01
`define UBBP_MODE_SYNC     8'h04
`define UBBP_DIR_RESET     8'h00
`define UBBP_PINS_RESET    8'h00
`define UBBP_BAUD_DIV      16'd10
`define UBBP_SETUP_CYCLES  1
`endif

/* shared/ubbp_pkg.sv */
package ubbp_pkg;
  typedef enum logic [4:0]
  {
    UBBP_IDLE    = 5'b00001,
    UBBP_SAMPLE  = 5'b00010,
    UBBP_APPLY   = 5'b00100,
    UBBP_SETUP   = 5'b01000,
    UBBP_STROBE  = 5'b10000
  } ubbp_state_type;
endpackage

/* shared/ubbp_if.sv */
`timescale 1ns/1ps
interface ubbp_if;
  logic [7:0] pins_out;
  logic [7:0] pins_oe;
  logic [7:0] pins_in;
  logic       pin_sample_strobe_n;
  logic       pin_update_strobe_n;
  modport device
  (
    output pins_out,
    output pins_oe,
    input  pins_in,
    output pin_sample_strobe_n,
    output pin_update_strobe_n
  );
  modport logic_end
  (
    input  pins_out,
    input  pins_oe,
    output pins_in,
    input  pin_sample_strobe_n,
    input  pin_update_strobe_n
  );
endinterface

/* rtl/ubbp_logic_end.sv */
`timescale 1ns/1ps
module ubbp_logic_end
(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] drive_in,
  output logic [7:0]      seen_pins,
  output logic            update_seen,
  output logic            sample_seen,
  ubbp_if.logic_end       port
);
  logic [7:0] drive_reg;
  logic [7:0] seen_reg;
  logic       upd_d_reg;
  logic       smp_d_reg;
  logic       update_seen_reg;
  logic       sample_seen_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Input pins reflect local drive; output pins read back what the device drives.
  assign port.pins_in = drive_reg;
  assign seen_pins    = seen_reg;
  assign update_seen  = update_seen_reg;
  assign sample_seen  = sample_seen_reg;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      drive_reg       <= 8'h00;
      seen_reg        <= 8'h00;
      upd_d_reg       <= 1'b1;
      smp_d_reg       <= 1'b1;
      update_seen_reg <= 1'b0;
      sample_seen_reg <= 1'b0;
    end
    else
    begin
      drive_reg       <= (drive_in & ~port.pins_oe) | (port.pins_out & port.pins_oe);
      upd_d_reg       <= port.pin_update_strobe_n;
      smp_d_reg       <= port.pin_sample_strobe_n;
      update_seen_reg <= upd_d_reg && !port.pin_update_strobe_n;
      // Rising edge of the sample strobe marks the captured value.
      sample_seen_reg <= !smp_d_reg && port.pin_sample_strobe_n; // RULE15
      if (upd_d_reg && !port.pin_update_strobe_n)
      begin
        seen_reg <= port.pins_out & port.pins_oe; // RULE17
      end
    end
  end
endmodule

/* testbench/ubbp_assertions.sv */
`timescale 1ns/1ps
module ubbp_assertions
(
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic [7:0] pins_out,
  input wire logic [7:0] pins_oe,
  input wire logic [7:0] pins_in,
  input wire logic       pin_sample_strobe_n,
  input wire logic       pin_update_strobe_n
);
  wire rd = pin_sample_strobe_n;
  wire wr = pin_update_strobe_n;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  idle_rst_a: assert property (!$past(nrst) |-> rd && wr) else $error("strobe busy");
  upd_pulse_a: assert property ($fell(wr) |=> wr && rd) else $error("update pulse");
  pin_chg_a: assert property ($changed(pins_out) |-> !rd) else $error("pins moved");
  setup_gap_a: assert property ($changed(pins_out) && wr |=> $fell(wr)) else $error("no setup gap");
  smp_first_a: assert property ($changed(pins_out) && wr |-> $past(rd)) else $error("no sample");
  upd_in_smp_a: assert property (!wr |-> !rd) else $error("strobe order");
  smp_short_a: assert property ($fell(rd) |-> ##[1:3] rd) else $error("sample stuck");
  // A mask may only move while no transfer is under way, or outputs glitch.
  dir_hold_a: assert property ($changed(pins_oe) |-> $past(rd) && $past(wr)) else $error("mask moved");
  pin_hold_a: assert property (!wr |=> $stable(pins_out)) else $error("pins not held");
  sync_c: cover property ($changed(pins_out) && wr);
  async_c: cover property ($fell(wr) && $fell(rd));
  dir_c: cover property ($changed(pins_oe) && pins_in != 8'h00);
endmodule

/* testbench/usb_parallel_bitbang_port_tb.sv */
`timescale 1ns/1ps
module usb_parallel_bitbang_port_tb;
  logic        sys_clk = 1'h0, nrst = 1'h0, setup_valid = 1'h0, rx_valid = 1'h0, tx_ready = 1'h1;
  logic [7:0]  setup_mode = 8'h00, setup_dir_mask = 8'h00, rx_data = 8'h00, drive_in = 8'h00;
  logic        rx_ready, tx_valid, took, update_seen, sample_seen;
  logic [7:0]  tx_data, mode, got, m, k, d, v, seen_pins, last = 8'h00;
  int          error_cnt = 0, checks = 0, upd_cnt = 0, smp_cnt = 0, u0 = 0, s0 = 0;
  logic [31:0] rows [7] = '{32'h04ff_5500, 32'h04ff_aa00, 32'h04ff_aa00, 32'h040f_3ca5,
                            32'h0400_ff5a, 32'h01f0_c300, 32'h01f0_3c00};
  ubbp_if      bus();
  ubbp_device #(.BAUD_DIV(16'h0004)) u_ubbp_device
  (
    .sys_clk, .nrst, .setup_valid, .setup_mode, .setup_dir_mask, .rx_valid, .rx_data,
    .rx_ready, .tx_ready, .tx_valid, .tx_data, .mode, .port(bus)
  );
  ubbp_logic_end u_ubbp_logic_end
  (
    .sys_clk, .nrst, .drive_in, .seen_pins, .update_seen, .sample_seen, .port(bus)
  );
  ubbp_assertions u_ubbp_assertions
  (
    .sys_clk, .nrst, .pins_out(bus.pins_out), .pins_oe(bus.pins_oe), .pins_in(bus.pins_in),
    .pin_sample_strobe_n(bus.pin_sample_strobe_n), .pin_update_strobe_n(bus.pin_update_strobe_n)
  );
  always #50 sys_clk = ~sys_clk;
  // Strobe pulses are only counted here, so each test compares differences of the totals.
  always @(posedge sys_clk)
  begin
    if (update_seen === 1'h1)
      upd_cnt++;
    if (sample_seen === 1'h1)
      smp_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic setup(input logic [7:0] sm, input logic [7:0] dm, input logic [7:0] dv);
    @(posedge sys_clk);
    setup_valid    <= 1'h1;
    setup_mode     <= sm;
    setup_dir_mask <= dm;
    drive_in       <= dv;
    @(posedge sys_clk);
    setup_valid <= 1'h0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic send(input logic [7:0] bd);
    int n;
    n = 0;
    got = 8'hxx;
    @(posedge sys_clk);
    rx_valid <= 1'h1;
    rx_data  <= bd;
    @(negedge sys_clk);
    while (rx_ready !== 1'h1 && n < 60)
    begin
      n++;
      @(negedge sys_clk);
    end
    took = (n < 60);
    @(posedge sys_clk);
    rx_valid <= 1'h0;
    repeat (6)
    begin
      @(negedge sys_clk);
      if (tx_valid === 1'h1)
        got = tx_data;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // The whole run needs about 200 cycles; ten times that means a hang.
  initial
  begin
    #200us;
    error_cnt++;
    results();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'h1;
    foreach (rows[i])
    begin
      {m, k, d, v} = rows[i];
      setup(m, k, v);
      u0 = upd_cnt;
      s0 = smp_cnt;
      send(d);
      chk("upd_cnt", 8'(upd_cnt - u0), 8'h01);
      chk("smp_edge", {7'h00, smp_cnt != s0}, 8'h01);
      chk("seen", seen_pins, d & k);
      chk("mode", mode, m);
      chk("dir", bus.pins_oe, k);
      chk("pins", bus.pins_out & k, d & k);
      if (m == 8'h04)
        chk("sample", got, (last & k) | (v & ~k));
      last = d;
      $display("row %0d done", i);
    end
    setup(8'h04, 8'hff, 8'h00);
    @(posedge sys_clk);
    tx_ready <= 1'h0;
    u0 = upd_cnt;
    send(8'h77);
    chk("room", {7'h00, took}, 8'h00);
    chk("room_upd", 8'(upd_cnt - u0), 8'h00);
    chk("hold", bus.pins_out, last);
    @(posedge sys_clk);
    tx_ready <= 1'h1;
    $display("room test done");
    @(posedge sys_clk);
    nrst <= 1'h0;
    @(negedge sys_clk);
    chk("idle", {6'h00, bus.pin_sample_strobe_n, bus.pin_update_strobe_n}, 8'h03);
    chk("rst", bus.pins_oe | mode, 8'h00);
    @(posedge sys_clk);
    nrst <= 1'h1;
    setup(8'h04, 8'hff, 8'h00);
    u0 = upd_cnt;
    send(8'h5a);
    chk("rst_smp", got, 8'h00);
    chk("rst_pins", bus.pins_out, 8'h5a);
    chk("rst_upd", 8'(upd_cnt - u0), 8'h01);
    $display("reset test done");
    results();
  end
endmodule
